// file: src/dac_serial_core.sv
/*
 * Serial command handling of a dual-channel converter: 24-bit input shift
 * register on the serial clock, direct write-and-update, chain passthrough,
 * register readback and per-channel power modes.
 * Assumes the serial clock may stop while frame select is high, that frame
 * select stays high for at least three i_clk periods between frames, and
 * that the host keeps the serial clock low while frame select is high.
 */
`timescale 1ns/1ns
`include "dac_serial_params.svh"

// Contract
// (RULE1) Command 0011 writes and updates addressed channel.
// (RULE2) Command 1000 sets chain mode from bit 0.
// (RULE3) Extra clocks in chain mode ripple out.
// (RULE4) Output changes on rising serial clock edges.
// (RULE5) Host sends 24 clocks per chained device.
// (RULE6) Short or odd frames still execute.
// (RULE7) Frame select rising latches, blocks further shifting.
// (RULE8) Host gates clock or holds exact count.
// (RULE9) Command 1001 arms readback, ignores data bits.
// (RULE10) Readback enables output despite standalone mode.
// (RULE11) One address bit selects; otherwise channel A.
// (RULE12) Readback data leaves during the next frame.
// (RULE13) Four undefined bits, then register bits 19..4; the code sends eight zero bits before register bits 19..4.
// (RULE14) Host reads channel A with 0x900000, 0x000000.
// (RULE15) Command 0100 loads power modes from bits 7..0.
// (RULE16) Power codes: normal, 1k, 100k, high impedance.
// (RULE17) Channel B bits 7..6, channel A bits 1..0.
// (RULE18) Power-down keeps and still updates output registers.
// (RULE19) Active indication delayed 4.5 us after wake.
// (RULE20) Input sampled on falling edges, MSB first.
// (RULE21) Command, address B00A, then data word.
// (RULE22) Chain output is input register MSB.
// (RULE23) Output disabled when neither chain nor readback.
module dac_serial_core
   import dac_serial_pkg::*;
#(
   parameter int WAKE_CYCLES = `WAKE_CYCLES
)
(
   input  wire logic                        i_clk,
   input  wire logic                        i_srst,
   input  wire logic                        i_ce,
   input  wire logic                        i_sclk,
   input  wire logic                        i_sync_n,
   input  wire logic                        i_serial_data_in,
   output logic                             o_serial_data_out,
   output logic                             o_serial_data_out_oe,
   output logic                             o_chain_enable,
   output logic                             o_readback_armed,
   output logic                             o_frame_done,
   output logic [`FRAME_BITS-1:0]           o_last_frame,
   output logic [`DATA_BITS-1:0]            o_dac_data_a,
   output logic [`DATA_BITS-1:0]            o_dac_data_b,
   output logic                             o_dac_update_a,
   output logic                             o_dac_update_b,
   output dac_serial_pkg::power_mode_t      o_power_mode_a,
   output dac_serial_pkg::power_mode_t      o_power_mode_b,
   output logic                             o_chan_active_a,
   output logic                             o_chan_active_b,
   output logic                             o_power_fill_error
);

   import dac_serial_pkg::*;

   localparam int NUM_CH = 2;

   // Link domain state.
   logic [`FRAME_BITS-1:0] shift_r;
   logic [`FRAME_BITS-1:0] out_shift_r;
   logic                   first_edge_r;
   logic                   sdo_r;

   // Core domain state.
   frame_state_t           state_r;
   frame_state_t           state_nxt;
   logic                   sync_q;
   logic                   frame_end;
   cmd_t                   cmd;
   logic [3:0]             addr;
   logic                   chain_r;
   logic                   rb_pending_r;
   logic [`FRAME_BITS-1:0] rb_word_r;
   logic [`FRAME_BITS-1:0] last_frame_r;
   logic                   frame_done_r;
   logic                   oe_r;
   logic                   fill_err_r;
   logic [`DATA_BITS-1:0]  data_r   [NUM_CH];
   logic                   update_r [NUM_CH];
   power_mode_t            pwr_r    [NUM_CH];
   logic                   active   [NUM_CH];
   logic                   rb_sel_b;
   logic [19:0]            rb_view;

   // Serial clock domain.

   // (RULE20) Falling-edge MSB-first sampling.
   // (RULE7) Shifting stops while frame select is high.
   // (RULE3) Every pulse in a frame shifts.
   always_ff @(negedge i_sclk)
   begin
      if (!i_sync_n)
      begin
         shift_r <= {shift_r[`FRAME_BITS-2:0], i_serial_data_in};
      end
   end

   // Frame select high forces the first-edge marker to its constant.
   always_ff @(posedge i_sclk or posedge i_sync_n)
   begin
      if (i_sync_n)
      begin
         first_edge_r <= 1'h1;
      end
      else
      begin
         first_edge_r <= 1'h0;
      end
   end

   // The readback word and pending flag only change between frames, so they
   // are steady whenever this domain samples them.
   // (RULE4) Output updated on rising edges.
   always_ff @(posedge i_sclk)
   begin
      if (!i_sync_n)
      begin
         if (rb_pending_r)
         begin
            // (RULE12) Readback word shifted out.
            if (first_edge_r)
            begin
               sdo_r       <= rb_word_r[`FRAME_BITS-1];
               out_shift_r <= {rb_word_r[`FRAME_BITS-2:0], 1'h0};
            end
            else
            begin
               sdo_r       <= out_shift_r[`FRAME_BITS-1];
               out_shift_r <= {out_shift_r[`FRAME_BITS-2:0], 1'h0};
            end
         end
         else
         begin
            // (RULE22) Chain output from input MSB.
            sdo_r <= shift_r[`FRAME_BITS-1];
         end
      end
   end

   assign o_serial_data_out = sdo_r;

   // Core clock domain.

   level_sync
   #(
      .RESET_VALUE (1'h1)
   )
   u_sync_frame
   (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_ce    (i_ce),
      .i_async (i_sync_n),
      .o_sync  (sync_q)
   );

   always_comb
   begin
      state_nxt = state_r;
      frame_end = 1'h0;
      case (state_r)
         FS_IDLE:
         begin
            if (!sync_q)
            begin
               state_nxt = FS_ACTIVE;
            end
         end
         FS_ACTIVE:
         begin
            // (RULE7) Rising frame select latches.
            if (sync_q)
            begin
               state_nxt = FS_IDLE;
               frame_end = 1'h1;
            end
         end
         default:
         begin
            state_nxt = FS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         state_r <= FS_IDLE;
      end
      else if (i_ce)
      begin
         state_r <= state_nxt;
      end
   end

   // The shift register is stable once frame select has been seen high.
   // (RULE21) Command and address fields.
   assign cmd  = cmd_t'(shift_r[`CMD_MSB:`CMD_LSB]);
   assign addr = shift_r[`ADDR_MSB:`ADDR_LSB];

   // (RULE6) Every frame end executes, whatever the count.
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         frame_done_r <= 1'h0;
         last_frame_r <= '0;
      end
      else if (i_ce)
      begin
         frame_done_r <= frame_end;
         if (frame_end)
         begin
            last_frame_r <= shift_r;
         end
      end
   end

   // (RULE2) Chain mode from bit 0.
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         chain_r <= `CHAIN_RST;
      end
      else if (i_ce && frame_end && cmd == CMD_CHAIN)
      begin
         chain_r <= shift_r[`CHAIN_BIT];
      end
   end

   // (RULE11) Only a lone B bit selects channel B.
   assign rb_sel_b = (addr == `ADDR_ONLY_B);
   assign rb_view  = {4'h0, (rb_sel_b ? data_r[1] : data_r[0])};

   // (RULE9) Readback armed for the following frame only.
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         rb_pending_r <= 1'h0;
         rb_word_r    <= '0;
      end
      else if (i_ce && frame_end)
      begin
         rb_pending_r <= (cmd == CMD_READBACK);
         if (cmd == CMD_READBACK)
         begin
            // (RULE13) Zero byte, then register bits 19..4.
            rb_word_r <= {8'h00, rb_view[`RB_DATA_MSB:`RB_DATA_LSB]};
         end
      end
   end

   // (RULE10) Readback drives the output in standalone mode.
   // (RULE23) Otherwise the output stays released.
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         oe_r <= 1'h0;
      end
      else if (i_ce)
      begin
         oe_r <= chain_r || (rb_pending_r && state_r == FS_ACTIVE && !sync_q);
      end
   end

   // (RULE17) Fill bits expected as ones.
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         fill_err_r <= 1'h0;
      end
      else if (i_ce && frame_end && cmd == CMD_POWER)
      begin
         fill_err_r <= (shift_r[`PWR_FILL_MSB:`PWR_FILL_LSB] != `PWR_FILL_ONES);
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch = ch + 1)
      begin : g_chan
         localparam int APOS = (ch == 0) ? `ADDR_A_BIT : `ADDR_B_BIT;
         localparam int PPOS = (ch == 0) ? `PWR_A_LSB : `PWR_B_LSB;

         // (RULE1) Write and update addressed channel.
         // (RULE18) Updates regardless of power mode.
         always_ff @(posedge i_clk)
         begin
            if (i_srst)
            begin
               data_r[ch]   <= `DATA_RST;
               update_r[ch] <= 1'h0;
            end
            else if (i_ce)
            begin
               update_r[ch] <= 1'h0;
               if (frame_end && cmd == CMD_WRITE_UPDATE && shift_r[APOS])
               begin
                  data_r[ch]   <= shift_r[`DATA_MSB:`DATA_LSB];
                  update_r[ch] <= 1'h1;
               end
            end
         end

         // (RULE15) Power fields loaded together.
         // (RULE16) Two-bit mode code per channel.
         always_ff @(posedge i_clk)
         begin
            if (i_srst)
            begin
               pwr_r[ch] <= power_mode_t'(`PWR_RST);
            end
            else if (i_ce && frame_end && cmd == CMD_POWER)
            begin
               pwr_r[ch] <= power_mode_t'(shift_r[PPOS+1:PPOS]);
            end
         end

         // (RULE19) Delayed active indication.
         wake_timer
         #(
            .WAKE_CYCLES (WAKE_CYCLES)
         )
         u_wake
         (
            .i_clk    (i_clk),
            .i_srst   (i_srst),
            .i_ce     (i_ce),
            .i_mode   (pwr_r[ch]),
            .o_active (active[ch])
         );
      end
   endgenerate

   assign o_serial_data_out_oe = oe_r;
   assign o_chain_enable       = chain_r;
   assign o_readback_armed     = rb_pending_r;
   assign o_frame_done         = frame_done_r;
   assign o_last_frame         = last_frame_r;
   assign o_power_fill_error   = fill_err_r;
   assign o_dac_data_a         = data_r[0];
   assign o_dac_data_b         = data_r[1];
   assign o_dac_update_a       = update_r[0];
   assign o_dac_update_b       = update_r[1];
   assign o_power_mode_a       = pwr_r[0];
   assign o_power_mode_b       = pwr_r[1];
   assign o_chan_active_a      = active[0];
   assign o_chan_active_b      = active[1];

endmodule

// file: src/dac_serial_params.svh
/*
 * Constants for the dual-channel converter serial command block: frame field
 * positions, reset values and timing counts.
 * Assumes it is included by its bare name and that the clock runs at 10 ns.
 */
`ifndef DAC_SERIAL_PARAMS_SVH
`define DAC_SERIAL_PARAMS_SVH

`define FRAME_BITS       24
`define CMD_MSB          23
`define CMD_LSB          20
`define ADDR_MSB         19
`define ADDR_LSB         16
`define ADDR_B_BIT       19
`define ADDR_A_BIT       16
`define DATA_MSB         15
`define DATA_LSB         0
`define DATA_BITS        16
`define CHAIN_BIT        0
`define PWR_B_LSB        6
`define PWR_A_LSB        0
`define PWR_FILL_MSB     5
`define PWR_FILL_LSB     2
`define RB_DATA_MSB      19
`define RB_DATA_LSB      4

`define CHAIN_RST        1'h0
`define PWR_RST          2'h0
`define DATA_RST         16'h0000
`define ADDR_ONLY_B      4'h8
`define PWR_FILL_ONES    4'hF

`define CLK_PERIOD_NS    10
`define WAKE_TIME_NS     4500
`define WAKE_CYCLES      ((`WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: src/dac_serial_pkg.sv
/*
 * Types shared by the serial command block: command codes, channel power
 * modes and the frame tracking states.
 * Assumes nothing of its surroundings.
 */
package dac_serial_pkg;

   typedef enum logic [3:0]
   {
      CMD_NOP          = 4'h0,
      CMD_WRITE_UPDATE = 4'h3,
      CMD_POWER        = 4'h4,
      CMD_CHAIN        = 4'h8,
      CMD_READBACK     = 4'h9
   } cmd_t;

   typedef enum logic [1:0]
   {
      PM_NORMAL    = 2'h0,
      PM_PULL_1K   = 2'h1,
      PM_PULL_100K = 2'h2,
      PM_HIGH_Z    = 2'h3
   } power_mode_t;

   typedef enum logic [0:0]
   {
      FS_IDLE   = 1'h0,
      FS_ACTIVE = 1'h1
   } frame_state_t;

endpackage

// file: src/level_sync.sv
/*
 * Two-flop synchroniser for one level crossing into the i_clk domain.
 * Assumes the input is a slowly changing level; the first flop feeds only
 * the second.
 */
`timescale 1ns/1ns
module level_sync
#(
   parameter logic RESET_VALUE = 1'h1
)
(
   input  wire logic i_clk,
   input  wire logic i_srst,
   input  wire logic i_ce,
   input  wire logic i_async,
   output logic      o_sync
);

   logic meta_r;

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         meta_r <= RESET_VALUE;
         o_sync <= RESET_VALUE;
      end
      else if (i_ce)
      begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end

endmodule

// file: src/wake_timer.sv
/*
 * Per-channel power-up delay: the active indication follows the normal
 * mode only after a fixed number of clock cycles.
 * Assumes the mode input comes from logic on the same clock.
 */
`timescale 1ns/1ns
module wake_timer
   import dac_serial_pkg::*;
#(
   parameter int WAKE_CYCLES = 450
)
(
   input  wire logic                        i_clk,
   input  wire logic                        i_srst,
   input  wire logic                        i_ce,
   input  wire dac_serial_pkg::power_mode_t i_mode,
   output logic                             o_active
);

   localparam int CW = $clog2(WAKE_CYCLES + 1);

   logic [CW-1:0] count_r;

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         count_r  <= '0;
         o_active <= 1'h1;
      end
      else if (i_ce)
      begin
         if (i_mode != PM_NORMAL)
         begin
            count_r  <= '0;
            o_active <= 1'h0;
         end
         else if (!o_active)
         begin
            if (count_r == CW'(WAKE_CYCLES - 1))
            begin
               o_active <= 1'h1;
            end
            count_r <= count_r + CW'(1);
         end
      end
   end

endmodule

// file: tb/dac_serial_core_asserts.sv
/*
 * Concurrent checks on the ports of the serial command core.
 * Assumes it is bound to the core with WAKE_CYCLES handed on.
 */
`timescale 1ns/1ns
`include "dac_serial_params.svh"
module dac_serial_core_checker
   import dac_serial_pkg::*;
#(
   parameter int WAKE_CYCLES = 450
)
(
   input wire logic                        i_clk,
   input wire logic                        i_srst,
   input wire logic                        i_sync_n,
   input wire logic                        o_serial_data_out_oe,
   input wire logic                        o_chain_enable,
   input wire logic                        o_readback_armed,
   input wire logic                        o_frame_done,
   input wire logic [`DATA_BITS-1:0]       o_dac_data_a,
   input wire logic                        o_dac_update_a,
   input wire logic                        o_dac_update_b,
   input wire dac_serial_pkg::power_mode_t o_power_mode_a,
   input wire logic                        o_chan_active_a
);
   localparam int WAKE_MAX = WAKE_CYCLES + 2;
   default clocking dflt @(posedge i_clk); endclocking
   default disable iff (i_srst);
   sequence s_wake;
      $past(o_power_mode_a) != PM_NORMAL && o_power_mode_a == PM_NORMAL;
   endsequence
   sequence s_rb_open;
      (o_readback_armed && !i_sync_n) [*5];
   endsequence
   a_update_in_frame: assert property ((o_dac_update_a || o_dac_update_b) |-> o_frame_done)
      else $error("update pulse outside frame completion");
   a_done_pulse: assert property (o_frame_done |=> !o_frame_done)
      else $error("frame done longer than one cycle");
   a_done_after_sel: assert property ($rose(i_sync_n) |-> ##[1:5] o_frame_done)
      else $error("frame end not executed");
   a_data_hold: assert property ($changed(o_dac_data_a) |-> o_dac_update_a)
      else $error("output register changed without a write");
   a_power_idle: assert property (o_power_mode_a != PM_NORMAL |=> !o_chan_active_a)
      else $error("channel active while powered down");
   a_wake_delay: assert property (s_wake |-> !o_chan_active_a [*4] ##[1:WAKE_MAX] o_chan_active_a)
      else $error("wake delay wrong");
   a_rb_drive: assert property (s_rb_open |-> o_serial_data_out_oe)
      else $error("readback frame without output enable");
   a_chain_drive: assert property (o_chain_enable [*2] |-> o_serial_data_out_oe)
      else $error("chain mode without output enable");
   a_out_idle: assert property ((!o_chain_enable && !o_readback_armed) [*3] |-> !o_serial_data_out_oe)
      else $error("output driven while idle");
endmodule

// file: tb/host_serial_model.sv
/*
 * Host serial controller: sends exact bursts MSB first on a gated serial
 * clock and captures the serial output on falling edges.
 * Assumes i_clk is the core clock, used only to start frames.
 */
`timescale 1ns/1ns
module host_serial_model
(
   input  wire logic i_clk,
   input  wire logic i_sdo,
   input  wire logic i_oe,
   output logic      o_sclk,
   output logic      o_sync_n,
   output logic      o_sdi
);
   logic held;
   wire  line_lvl;
   initial
   begin
      o_sclk = 0;
      o_sync_n = 1;
      o_sdi = 0;
      held = 0;
   end
   // A released output line shows the inverse of its last driven level.
   assign line_lvl = i_oe ? i_sdo : ~held;
   always @(negedge o_sclk)
      if (i_oe)
         held = i_sdo;
   task xfer(input [47:0] d, input int n, output [47:0] q);
      q = 0;
      @(posedge i_clk);
      o_sync_n <= 0;
      #43;
      for (int i = n - 1; i >= 0; i--)
      begin
         o_sdi <= d[i];
         #8 o_sclk <= 1;
         #16 q = {q[46:0], line_lvl};
         o_sclk <= 0;
         #8;
      end
      o_sync_n <= 1;
   endtask
endmodule

// file: tb/dac_serial_chain_readback_powerdown_bench.sv
/*
 * Self-checking bench for the serial command core with a reference model.
 * Assumes the checker and host model files are compiled before it.
 */
`timescale 1ns/1ns
module dac_serial_chain_readback_powerdown_bench;
   import dac_serial_pkg::*;
   localparam int WAKE = 8;
   logic        clk = 0, srst = 1, sclk, sync_n, sdi, serial_data_out, oe, chn, arm, done;
   logic        ua, ub, aa, ab, fe, ce = 1'h1, mch = 0, marm = 0, mfe = 0;
   logic [23:0] last, sr = 0;
   logic [15:0] da, db, ma = 0, mb = 0, rbv = 0;
   logic [1:0]  mpa = 0, mpb = 0, opa = 0, opb = 0;
   logic [3:0]  adr [4] = '{4'h1, 4'h8, 4'h9, 4'h0};
   logic [23:0] rbc [4] = '{24'h910000, 24'h980000, 24'h990000, 24'h900000};
   power_mode_t pa, pb;
   int          err_total = 0, cmp_count = 0, seed = 32'h6780, k;
   always #5 clk = ~clk;
   dac_serial_core #(.WAKE_CYCLES(WAKE)) u_dut
   (
      .i_clk(clk), .i_srst(srst), .i_ce(ce), .i_sclk(sclk), .i_sync_n(sync_n),
      .i_serial_data_in(sdi), .o_serial_data_out(serial_data_out), .o_serial_data_out_oe(oe),
      .o_chain_enable(chn), .o_readback_armed(arm), .o_frame_done(done),
      .o_last_frame(last), .o_dac_data_a(da), .o_dac_data_b(db),
      .o_dac_update_a(ua), .o_dac_update_b(ub), .o_power_mode_a(pa),
      .o_power_mode_b(pb), .o_chan_active_a(aa), .o_chan_active_b(ab),
      .o_power_fill_error(fe)
   );
   host_serial_model u_host
   (
      .i_clk(clk), .i_sdo(serial_data_out), .i_oe(oe), .o_sclk(sclk), .o_sync_n(sync_n), .o_sdi(sdi)
   );
   task chk(input [47:0] g, input [47:0] e);
      cmp_count++;
      if (g !== e)
      begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task stop_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk_all;
      chk(last, sr);
      chk({da, db}, {ma, mb});
      chk(chn, mch);
      chk(arm, marm);
      chk({pb, pa}, {mpb, mpa});
      chk(fe, mfe);
      chk(oe, mch);
      chk({ab, aa}, {mpb == 0 && opb == 0, mpa == 0 && opa == 0});
   endtask
   // Shifts the model register bit by bit, which also yields the chain output.
   task frame(input [47:0] d, input int n);
      logic [47:0] q, ex;
      logic [3:0]  c;
      logic        pch, parm;
      int          i;
      pch = mch;
      parm = marm;
      ex = 0;
      u_host.xfer(d, n, q);
      for (i = n - 1; i >= 0; i--)
      begin
         ex = {ex[46:0], sr[23]};
         sr = {sr[22:0], d[i]};
      end
      i = 0;
      while (done !== 1'b1 && i < 20)
      begin
         @(posedge clk);
         #1 i++;
      end
      c = sr[23:20];
      chk(done, 1'b1);
      chk({ub, ua}, {c == 4'h3 && sr[19], c == 4'h3 && sr[16]});
      if (parm && n == 24)
         chk(q[19:0], {4'h0, rbv[15:4]});
      else if (pch)
         chk(q, ex);
      opa = mpa;
      opb = mpb;
      marm = 0;
      case (c)
         4'h3:
         begin
            if (sr[16])
               ma = sr[15:0];
            if (sr[19])
               mb = sr[15:0];
         end
         4'h4:
         begin
            mpa = sr[1:0];
            mpb = sr[7:6];
            mfe = sr[5:2] != 4'hF;
         end
         4'h8: mch = sr[0];
         4'h9:
         begin
            marm = 1;
            rbv = (sr[19:16] == 4'h8) ? mb : ma;
         end
         default: ;
      endcase
      repeat (2) @(posedge clk);
      #1 chk_all;
   endtask
   initial
   begin
      #200000 err_total++;
      stop_test;
   end
   initial
   begin
      repeat (8) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      #1 chk_all;
      for (k = 0; k < 6; k++)
         frame({4'h3, adr[k % 4], 16'($random(seed))}, 24);
      for (k = 0; k < 4; k++)
      begin
         frame(48'(24'h40003C | (k << 6) | (3 - k)), 24);
         frame({8'h39, 16'($random(seed))}, 24);
      end
      frame(24'h400000, 24);
      // A low clock enable must freeze the wake counter of channel B.
      @(posedge clk);
      ce <= 1'h0;
      repeat (WAKE + 4) @(posedge clk);
      #1 chk({ab, aa}, 2'h1);
      @(posedge clk);
      ce <= 1'h1;
      repeat (WAKE + 2) @(posedge clk);
      #1 chk({ab, aa}, 2'h3);
      for (k = 0; k < 4; k++)
      begin
         frame(rbc[k], 24);
         frame(24'h000000, 24);
      end
      frame(24'h800001, 24);
      frame({32'($random(seed)), 16'($random(seed))}, 48);
      frame(24'h000000, 24);
      frame(24'h800000, 24);
      frame(24'($random(seed)), 16);
      frame(24'h000000, 24);
      stop_test;
   end
endmodule
bind dac_serial_core dac_serial_core_checker #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk
(
   .i_clk(i_clk), .i_srst(i_srst), .i_sync_n(i_sync_n),
   .o_serial_data_out_oe(o_serial_data_out_oe), .o_chain_enable(o_chain_enable),
   .o_readback_armed(o_readback_armed), .o_frame_done(o_frame_done),
   .o_dac_data_a(o_dac_data_a), .o_dac_update_a(o_dac_update_a),
   .o_dac_update_b(o_dac_update_b), .o_power_mode_a(o_power_mode_a),
   .o_chan_active_a(o_chan_active_a)
);
